// [hw/carc_core.sv]
// address register datapath with scratchpad, reached over apb
//
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/1ps
module carc_core
    import carc_pkg::*;
#(
    parameter int SP_DEPTH = 64
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic      [15:0] mem_addr,
    output logic      [7:0]  mem_wdata,
    output logic             mem_read,
    output logic             mem_write,
    input  wire logic [7:0]  mem_rdata
);
    logic [7:0]  acc_reg;
    logic [3:0]  flags_reg;
    logic [15:0] ip_reg;
    logic [15:0] ret_reg;
    logic [15:0] dp_reg;
    logic [15:0] dp2_reg;
    logic [5:0]  ptr_reg;
    logic [5:0]  sidx_reg;
    logic [7:0]  last_op_reg;
    logic [7:0]  sp_mem [SP_DEPTH];

    logic        acc_wr;
    logic        exec;
    carc_instr_t ins;
    logic [3:0]  rf;
    logic [5:0]  sp_addr;
    logic [7:0]  sp_rdata;
    logic [15:0] ip_seq1;
    logic [15:0] ip_next;
    logic [15:0] ret_next;
    logic [15:0] dp_next;
    logic [15:0] dp2_next;
    logic [5:0]  ptr_next;
    logic [7:0]  acc_next;
    logic [3:0]  flags_next;
    logic        acc_we;
    logic        flags_we;
    logic        ret_we;
    logic        dp_we;
    logic        dp2_we;
    logic        ptr_we;
    logic        wa_en;
    logic [5:0]  wa_addr;
    logic [7:0]  wa_data;
    logic        wb_en;
    logic [5:0]  wb_addr;
    logic [7:0]  wb_data;
    logic        taken;
    logic [15:0] disp;
    logic        mapped;
    logic [31:0] rd_mux;

    assign acc_wr = psel & penable & pwrite;
    assign exec   = acc_wr & (paddr == CARC_OFF_EXEC);
    assign ins    = carc_instr_t'(pwdata[23:0]);
    assign rf     = ins.op[3:0];
    assign ip_seq1 = ip_reg + 16'h0001;
    // displacement is counted from the byte after the branch opcode
    assign disp   = {{8{ins.b1[7]}}, ins.b1};

    // register field picks a direct entry or the scratch pointer
    always_comb begin
        if (rf <= CARC_RF_DIRECT_MAX) begin
            sp_addr = {2'b00, rf};
        end else begin
            sp_addr = ptr_reg;
        end
    end
    assign sp_rdata = sp_mem[sp_addr];

    // branch condition evaluation
    always_comb begin
        taken = 1'b0;
        if (ins.op == CARC_OP_BR7) begin
            taken = (ptr_reg[2:0] != 3'b111);
        end else if (ins.op == CARC_OP_BRA) begin
            taken = 1'b1;
        end else if (ins.op[7:4] == CARC_OG_BR_TRUE
                     && ins.op[3] == 1'b0) begin
            taken = |(flags_reg[2:0] & ins.op[2:0]);
        end else if (ins.op[7:4] == CARC_OG_BR_FALSE) begin
            taken = ~|(flags_reg & ins.op[3:0]);
        end
    end

    // instruction execution: next values and write enables
    always_comb begin
        ip_next    = ip_seq1;
        ret_next   = ret_reg;
        dp_next    = dp_reg;
        dp2_next   = dp2_reg;
        ptr_next   = ptr_reg;
        acc_next   = acc_reg;
        flags_next = flags_reg;
        acc_we     = 1'b0;
        flags_we   = 1'b0;
        ret_we     = 1'b0;
        dp_we      = 1'b0;
        dp2_we     = 1'b0;
        ptr_we     = 1'b0;
        wa_en      = 1'b0;
        wa_addr    = CARC_SP_KU;
        wa_data    = acc_reg;
        wb_en      = 1'b0;
        wb_addr    = CARC_SP_KL;
        wb_data    = acc_reg;
        mem_read   = 1'b0;
        mem_write  = 1'b0;
        case (ins.op)
            CARC_OP_A_KU: begin
                acc_next = sp_mem[CARC_SP_KU];
                acc_we   = 1'b1;
            end
            CARC_OP_A_KL: begin
                acc_next = sp_mem[CARC_SP_KL];
                acc_we   = 1'b1;
            end
            CARC_OP_A_QU: begin
                acc_next = sp_mem[CARC_SP_QU];
                acc_we   = 1'b1;
            end
            CARC_OP_A_QL: begin
                acc_next = sp_mem[CARC_SP_QL];
                acc_we   = 1'b1;
            end
            CARC_OP_KU_A: begin
                wa_en = 1'b1;
            end
            CARC_OP_KL_A: begin
                wa_en   = 1'b1;
                wa_addr = CARC_SP_KL;
            end
            CARC_OP_QU_A: begin
                wa_en   = 1'b1;
                wa_addr = CARC_SP_QU;
            end
            CARC_OP_QL_A: begin
                wa_en   = 1'b1;
                wa_addr = CARC_SP_QL;
            end
            CARC_OP_K_RET: begin
                wa_en   = 1'b1;
                wa_data = ret_reg[15:8];
                wb_en   = 1'b1;
                wb_data = ret_reg[7:0];
            end
            CARC_OP_RET_K: begin
                ret_next = {sp_mem[CARC_SP_KU], sp_mem[CARC_SP_KL]};
                ret_we   = 1'b1;
            end
            CARC_OP_A_PTR: begin
                acc_next = {2'b00, ptr_reg};
                acc_we   = 1'b1;
            end
            CARC_OP_PTR_A: begin
                ptr_next = acc_reg[5:0];
                ptr_we   = 1'b1;
            end
            CARC_OP_CALLK: begin
                ret_next = ip_seq1;
                ret_we   = 1'b1;
                ip_next  = {sp_mem[CARC_SP_KU], sp_mem[CARC_SP_KL]};
            end
            CARC_OP_JMPQ: begin
                ip_next = {sp_mem[CARC_SP_QU], sp_mem[CARC_SP_QL]};
            end
            CARC_OP_Q_DP: begin
                wa_en   = 1'b1;
                wa_addr = CARC_SP_QU;
                wa_data = dp_reg[15:8];
                wb_en   = 1'b1;
                wb_addr = CARC_SP_QL;
                wb_data = dp_reg[7:0];
            end
            CARC_OP_DP_Q: begin
                dp_next = {sp_mem[CARC_SP_QU], sp_mem[CARC_SP_QL]};
                dp_we   = 1'b1;
            end
            CARC_OP_DP_H: begin
                dp_next = {sp_mem[CARC_SP_HU], sp_mem[CARC_SP_HL]};
                dp_we   = 1'b1;
            end
            CARC_OP_H_DP: begin
                wa_en   = 1'b1;
                wa_addr = CARC_SP_HU;
                wa_data = dp_reg[15:8];
                wb_en   = 1'b1;
                wb_addr = CARC_SP_HL;
                wb_data = dp_reg[7:0];
            end
            CARC_OP_LOADM: begin
                mem_read = exec;
                acc_next = mem_rdata;
                acc_we   = 1'b1;
                dp_next  = dp_reg + 16'h0001;
                dp_we    = 1'b1;
            end
            CARC_OP_STOREM: begin
                mem_write = exec;
                dp_next   = dp_reg + 16'h0001;
                dp_we     = 1'b1;
            end
            CARC_OP_RETURN: begin
                ip_next = ret_reg;
            end
            CARC_OP_W_J: begin
                flags_next = sp_mem[CARC_SP_FLAGSAVE][3:0];
                flags_we   = 1'b1;
            end
            CARC_OP_J_W: begin
                wa_en   = 1'b1;
                wa_addr = CARC_SP_FLAGSAVE;
                wa_data = {4'h0, flags_reg};
            end
            CARC_OP_LI: begin
                acc_next = ins.b1;
                acc_we   = 1'b1;
                ip_next  = ip_reg + 16'h0002;
            end
            CARC_OP_CALL: begin
                ret_next = ip_reg + 16'h0003;
                ret_we   = 1'b1;
                ip_next  = {ins.b1, ins.b2};
            end
            CARC_OP_JUMP: begin
                ip_next = {ins.b1, ins.b2};
            end
            CARC_OP_DPIMM: begin
                dp_next = {ins.b1, ins.b2};
                dp_we   = 1'b1;
                ip_next = ip_reg + 16'h0003;
            end
            CARC_OP_XDP: begin
                dp_next  = dp2_reg;
                dp_we    = 1'b1;
                dp2_next = dp_reg;
                dp2_we   = 1'b1;
            end
            CARC_OP_ADDDP: begin
                dp_next = dp_reg + {{8{acc_reg[7]}}, acc_reg};
                dp_we   = 1'b1;
            end
            default: begin
                case (ins.op[7:4])
                    CARC_OG_SP_LOAD: begin
                        acc_next = sp_rdata;
                        acc_we   = (rf <= CARC_RF_IND_DEC);
                    end
                    CARC_OG_SP_STORE: begin
                        wa_en   = (rf <= CARC_RF_IND_DEC);
                        wa_addr = sp_addr;
                    end
                    CARC_OG_PTR_HALF: begin
                        ptr_we = 1'b1;
                        if (ins.op[3]) begin
                            ptr_next = {ptr_reg[5:3], ins.op[2:0]};
                        end else begin
                            ptr_next = {ins.op[2:0], ptr_reg[2:0]};
                        end
                    end
                    CARC_OG_SHORT_LI: begin
                        acc_next = {4'h0, ins.op[3:0]};
                        acc_we   = 1'b1;
                    end
                    CARC_OG_BR_TRUE, CARC_OG_BR_FALSE: begin
                        ip_next = taken ? ip_seq1 + disp
                                        : ip_reg + 16'h0002;
                    end
                    default: begin
                    end
                endcase
                // step only the pointer after an incrementing or decrementing indirect access
                if ((ins.op[7:4] == CARC_OG_SP_LOAD
                     || ins.op[7:4] == CARC_OG_SP_STORE)) begin
                    if (rf == CARC_RF_IND_INC) begin
                        ptr_next = ptr_reg + 6'h01;
                        ptr_we   = 1'b1;
                    end else if (rf == CARC_RF_IND_DEC) begin
                        ptr_next = ptr_reg - 6'h01;
                        ptr_we   = 1'b1;
                    end
                end
            end
        endcase
    end

    assign mem_addr  = dp_reg;
    assign mem_wdata = acc_reg;

    // architectural registers: exec updates, else direct apb writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_reg   <= CARC_RST_BYTE;
            flags_reg <= CARC_RST_FLG;
            ptr_reg   <= CARC_RST_PTR;
            last_op_reg <= CARC_RST_BYTE;
        end else if (exec) begin
            last_op_reg <= ins.op;
            if (acc_we) acc_reg <= acc_next;
            if (flags_we) flags_reg <= flags_next;
            if (ptr_we) ptr_reg <= ptr_next;
        end else if (acc_wr) begin
            if (paddr == CARC_OFF_ACC) acc_reg <= pwdata[7:0];
            if (paddr == CARC_OFF_FLAGS) flags_reg <= pwdata[3:0];
            if (paddr == CARC_OFF_SPTR) ptr_reg <= pwdata[5:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ip_reg  <= CARC_RST_WORD;
            ret_reg <= CARC_RST_WORD;
            dp_reg  <= CARC_RST_WORD;
            dp2_reg <= CARC_RST_WORD;
        end else if (exec) begin
            ip_reg <= ip_next;
            if (ret_we) ret_reg <= ret_next;
            if (dp_we) dp_reg <= dp_next;
            if (dp2_we) dp2_reg <= dp2_next;
        end else if (acc_wr) begin
            if (paddr == CARC_OFF_IP) ip_reg <= pwdata[15:0];
            if (paddr == CARC_OFF_RET) ret_reg <= pwdata[15:0];
            if (paddr == CARC_OFF_DP) dp_reg <= pwdata[15:0];
            if (paddr == CARC_OFF_DP2) dp2_reg <= pwdata[15:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sidx_reg <= CARC_RST_PTR;
        end else if (acc_wr && paddr == CARC_OFF_SIDX) begin
            sidx_reg <= pwdata[5:0];
        end
    end

    // scratchpad entries, two instruction write ports plus apb window
    genvar gi;
    generate
        for (gi = 0; gi < SP_DEPTH; gi++) begin : g_sp
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sp_mem[gi] <= CARC_RST_BYTE;
                end else if (exec && wa_en && wa_addr == 6'(gi)) begin
                    sp_mem[gi] <= wa_data;
                end else if (exec && wb_en && wb_addr == 6'(gi)) begin
                    sp_mem[gi] <= wb_data;
                end else if (acc_wr && paddr == CARC_OFF_SDATA
                             && sidx_reg == 6'(gi)) begin
                    sp_mem[gi] <= pwdata[7:0];
                end
            end
        end
    endgenerate

    // read decode
    always_comb begin
        mapped = 1'b1;
        rd_mux = 32'h0000_0000;
        if (paddr == CARC_OFF_EXEC) begin
            rd_mux = {24'h000000, last_op_reg};
        end else if (paddr == CARC_OFF_ACC) begin
            rd_mux = {24'h000000, acc_reg};
        end else if (paddr == CARC_OFF_FLAGS) begin
            rd_mux = {28'h0000000, flags_reg};
        end else if (paddr == CARC_OFF_IP) begin
            rd_mux = {16'h0000, ip_reg};
        end else if (paddr == CARC_OFF_RET) begin
            rd_mux = {16'h0000, ret_reg};
        end else if (paddr == CARC_OFF_DP) begin
            rd_mux = {16'h0000, dp_reg};
        end else if (paddr == CARC_OFF_DP2) begin
            rd_mux = {16'h0000, dp2_reg};
        end else if (paddr == CARC_OFF_SPTR) begin
            rd_mux = {26'h0, ptr_reg};
        end else if (paddr == CARC_OFF_SIDX) begin
            rd_mux = {26'h0, sidx_reg};
        end else if (paddr == CARC_OFF_SDATA) begin
            rd_mux = {24'h000000, sp_mem[sidx_reg]};
        end else begin
            mapped = 1'b0;
        end
    end

    // read data and error captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr <= ~mapped;
        end
    end

    assign pready = psel & penable;
endmodule

// [inc/carc_pkg.sv]
// shared constants and types for the address register control block
package carc_pkg;
    // register byte offsets
    localparam logic [7:0] CARC_OFF_EXEC  = 8'h00;
    localparam logic [7:0] CARC_OFF_ACC   = 8'h04;
    localparam logic [7:0] CARC_OFF_FLAGS = 8'h08;
    localparam logic [7:0] CARC_OFF_IP    = 8'h0c;
    localparam logic [7:0] CARC_OFF_RET   = 8'h10;
    localparam logic [7:0] CARC_OFF_DP    = 8'h14;
    localparam logic [7:0] CARC_OFF_DP2   = 8'h18;
    localparam logic [7:0] CARC_OFF_SPTR  = 8'h1c;
    localparam logic [7:0] CARC_OFF_SIDX  = 8'h20;
    localparam logic [7:0] CARC_OFF_SDATA = 8'h24;
    // reset values
    localparam logic [7:0]  CARC_RST_BYTE = 8'h00;
    localparam logic [15:0] CARC_RST_WORD = 16'h0000;
    localparam logic [5:0]  CARC_RST_PTR  = 6'h00;
    localparam logic [3:0]  CARC_RST_FLG  = 4'h0;
    // status flag positions
    localparam int CARC_FLG_SIGN  = 0;
    localparam int CARC_FLG_CARRY = 1;
    localparam int CARC_FLG_ZERO  = 2;
    localparam int CARC_FLG_OVF   = 3;
    // dedicated scratchpad entries
    localparam logic [5:0] CARC_SP_FLAGSAVE = 6'h09;
    localparam logic [5:0] CARC_SP_HU       = 6'h0a;
    localparam logic [5:0] CARC_SP_HL       = 6'h0b;
    localparam logic [5:0] CARC_SP_KU       = 6'h0c;
    localparam logic [5:0] CARC_SP_KL       = 6'h0d;
    localparam logic [5:0] CARC_SP_QU       = 6'h0e;
    localparam logic [5:0] CARC_SP_QL       = 6'h0f;
    // register field values in scratchpad instructions
    localparam logic [3:0] CARC_RF_DIRECT_MAX = 4'hb;
    localparam logic [3:0] CARC_RF_IND_KEEP   = 4'hc;
    localparam logic [3:0] CARC_RF_IND_INC    = 4'hd;
    localparam logic [3:0] CARC_RF_IND_DEC    = 4'he;
    // full opcodes
    localparam logic [7:0] CARC_OP_A_KU   = 8'h00;
    localparam logic [7:0] CARC_OP_A_KL   = 8'h01;
    localparam logic [7:0] CARC_OP_A_QU   = 8'h02;
    localparam logic [7:0] CARC_OP_A_QL   = 8'h03;
    localparam logic [7:0] CARC_OP_KU_A   = 8'h04;
    localparam logic [7:0] CARC_OP_KL_A   = 8'h05;
    localparam logic [7:0] CARC_OP_QU_A   = 8'h06;
    localparam logic [7:0] CARC_OP_QL_A   = 8'h07;
    localparam logic [7:0] CARC_OP_K_RET  = 8'h08;
    localparam logic [7:0] CARC_OP_RET_K  = 8'h09;
    localparam logic [7:0] CARC_OP_A_PTR  = 8'h0a;
    localparam logic [7:0] CARC_OP_PTR_A  = 8'h0b;
    localparam logic [7:0] CARC_OP_CALLK  = 8'h0c;
    localparam logic [7:0] CARC_OP_JMPQ   = 8'h0d;
    localparam logic [7:0] CARC_OP_Q_DP   = 8'h0e;
    localparam logic [7:0] CARC_OP_DP_Q   = 8'h0f;
    localparam logic [7:0] CARC_OP_DP_H   = 8'h10;
    localparam logic [7:0] CARC_OP_H_DP   = 8'h11;
    localparam logic [7:0] CARC_OP_LOADM  = 8'h16;
    localparam logic [7:0] CARC_OP_STOREM = 8'h17;
    localparam logic [7:0] CARC_OP_RETURN = 8'h1c;
    localparam logic [7:0] CARC_OP_W_J    = 8'h1d;
    localparam logic [7:0] CARC_OP_J_W    = 8'h1e;
    localparam logic [7:0] CARC_OP_LI     = 8'h20;
    localparam logic [7:0] CARC_OP_CALL   = 8'h28;
    localparam logic [7:0] CARC_OP_JUMP   = 8'h29;
    localparam logic [7:0] CARC_OP_DPIMM  = 8'h2a;
    localparam logic [7:0] CARC_OP_XDP    = 8'h2c;
    localparam logic [7:0] CARC_OP_ADDDP  = 8'h8e;
    localparam logic [7:0] CARC_OP_BR7    = 8'h8f;
    localparam logic [7:0] CARC_OP_BRA    = 8'h90;
    // upper-nibble opcode groups
    localparam logic [3:0] CARC_OG_SP_LOAD  = 4'h4;
    localparam logic [3:0] CARC_OG_SP_STORE = 4'h5;
    localparam logic [3:0] CARC_OG_PTR_HALF = 4'h6;
    localparam logic [3:0] CARC_OG_SHORT_LI = 4'h7;
    localparam logic [3:0] CARC_OG_BR_TRUE  = 4'h8;
    localparam logic [3:0] CARC_OG_BR_FALSE = 4'h9;
    // instruction word written to the exec register
    typedef struct packed {
        logic [7:0] b2;
        logic [7:0] b1;
        logic [7:0] op;
    } carc_instr_t;
endpackage

// [dv/carc_chk.sv]
// concurrent checks on the address register control ports
`timescale 1ns/1ps
module carc_chk
    import carc_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic [7:0]  paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [15:0] mem_addr,
    input wire logic [7:0]  mem_wdata,
    input wire logic        mem_read,
    input wire logic        mem_write,
    input wire logic [7:0]  mem_rdata
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic       ex;
    logic [7:0] op;
    assign ex = psel && penable && pwrite && paddr == CARC_OFF_EXEC;
    assign op = pwdata[7:0];
    property p_rd; ex && op == CARC_OP_LOADM |-> mem_read && !mem_write; endproperty
    a_rd: assert property (p_rd) else $error("no read strobe");
    property p_wr; ex && op == CARC_OP_STOREM |-> mem_write && !mem_read; endproperty
    a_wr: assert property (p_wr) else $error("no write strobe");
    property p_inc; ex && op[7:1] == 7'h0b |=> mem_addr == $past(mem_addr) + 1; endproperty
    a_inc: assert property (p_inc) else $error("pointer not stepped");
    property p_ld; ex && op == CARC_OP_LOADM |=> mem_wdata == $past(mem_rdata); endproperty
    a_ld: assert property (p_ld) else $error("load lost");
    property p_li; ex && op == CARC_OP_LI |=> mem_wdata == $past(pwdata[15:8]); endproperty
    a_li: assert property (p_li) else $error("long immediate");
    property p_lis; ex && op[7:4] == CARC_OG_SHORT_LI |=> mem_wdata == ($past(op) & 8'h0f); endproperty
    a_lis: assert property (p_lis) else $error("short immediate");
    property p_dpi; ex && op == CARC_OP_DPIMM |=> mem_addr == {$past(pwdata[15:8]), $past(pwdata[23:16])}; endproperty
    a_dpi: assert property (p_dpi) else $error("pointer load");
    property p_add; ex && op == CARC_OP_ADDDP |=> mem_addr == $past(mem_addr) + 16'($signed($past(mem_wdata))); endproperty
    a_add: assert property (p_add) else $error("pointer add");
endmodule
bind carc_core carc_chk chk (.*);

// [dv/carc_mem_model.sv]
// memory model answering the block's data port
`timescale 1ns/1ps
module carc_mem_model (
    input  wire logic        pclk,
    input  wire logic [15:0] mem_addr,
    input  wire logic [7:0]  mem_wdata,
    input  wire logic        mem_read,
    input  wire logic        mem_write,
    output logic      [7:0]  mem_rdata
);
    logic [7:0] mem [256];
    logic [7:0] last_q = 8'h00;
    initial for (int i = 0; i < 256; i++) mem[i] = 8'(i * 7 + 3);
    // idle bus shows a toggling pattern, never the last byte
    assign mem_rdata = mem_read ? mem[mem_addr[7:0]] : ~last_q;
    always @(posedge pclk) begin
        if (mem_write) mem[mem_addr[7:0]] <= mem_wdata;
        last_q <= mem_rdata;
    end
endmodule

// [dv/tb_top.sv]
// self-checking bench for the address register control block
`timescale 1ns/1ps
module tb_top;
    import carc_pkg::*;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 0, mem_rdata, mem_wdata, v, d;
    logic [31:0] pwdata = 0, prdata;
    logic [15:0] mem_addr;
    logic        pready, pslverr, mem_read, mem_write;
    logic [3:0]  f;
    logic [32:0] exp_q[$];
    int          failures = 0, total_checks = 0, cyc = 0;
    always #5 pclk = ~pclk;
    carc_core DUT (.*);
    carc_mem_model MEM (.*);
    task automatic close_out;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge pclk) if (++cyc > 4000) begin
        failures++;
        close_out();
    end
    always @(posedge pclk) if (psel && penable && pready === 1'b1 && !pwrite) begin
        total_checks++;
        if ({pslverr, prdata} !== exp_q[0]) begin
            failures++;
            $display("wrong value at %0t: got %h want %h", $time, {pslverr, prdata}, exp_q[0]);
        end
        void'(exp_q.pop_front());
    end
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] x);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= x;
        @(posedge pclk) penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        penable <= 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic er = 0);
        exp_q.push_back({er, e});
        apb(0, a, 0);
    endtask
    task automatic ex(input logic [7:0] op, input logic [7:0] b2 = 0, input logic [7:0] b3 = 0);
        apb(1, CARC_OFF_EXEC, {8'h0, b3, b2, op});
    endtask
    task automatic br(input logic [7:0] op, input logic t);
        d = 8'($urandom);
        apb(1, CARC_OFF_IP, 32'h1000);
        ex(op, d);
        rd(CARC_OFF_IP, t ? 32'h1001 + {{24{d[7]}}, d} : 32'h1002);
    endtask
    initial begin
        void'($urandom(32'he60f));
        v = 8'($urandom);
        repeat (3) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        for (int i = 0; i < 10; i++) rd(8'(4 * i), 0);
        apb(1, 8'h28, 32'h5a);
        rd(8'h28, 0, 1);
        ex(CARC_OP_LI, v);
        rd(CARC_OFF_ACC, v);
        rd(CARC_OFF_IP, 2);
        for (int i = 0; i < 16; i++) begin
            ex({CARC_OG_SHORT_LI, 4'(i)});
            rd(CARC_OFF_ACC, i);
        end
        for (int r = 0; r < 12; r++) begin
            ex(CARC_OP_LI, v ^ 8'(r));
            ex({CARC_OG_SP_STORE, 4'(r)});
            apb(1, CARC_OFF_SIDX, r);
            rd(CARC_OFF_SDATA, v ^ 8'(r));
        end
        apb(1, CARC_OFF_SPTR, 63);
        ex({CARC_OG_SP_STORE, CARC_RF_IND_INC});
        rd(CARC_OFF_SPTR, 0);
        rd(CARC_OFF_ACC, v ^ 8'd11);
        apb(1, CARC_OFF_SIDX, 63);
        rd(CARC_OFF_SDATA, v ^ 8'd11);
        ex({CARC_OG_SP_LOAD, CARC_RF_IND_DEC});
        rd(CARC_OFF_ACC, v);
        ex({CARC_OG_SP_LOAD, CARC_RF_IND_KEEP});
        rd(CARC_OFF_SPTR, 63);
        ex(8'h65);
        ex(8'h6a);
        rd(CARC_OFF_SPTR, 32'h2a);
        br(CARC_OP_BR7, 1);
        ex(8'h6f);
        br(CARC_OP_BR7, 0);
        ex(CARC_OP_PTR_A);
        rd(CARC_OFF_SPTR, 6'(v ^ 8'd11));
        ex(CARC_OP_A_PTR);
        rd(CARC_OFF_ACC, 6'(v ^ 8'd11));
        f = 4'($urandom);
        apb(1, CARC_OFF_FLAGS, f);
        for (int j = 0; j < 16; j++) begin
            br(8'h90 | 8'(j), (f & 4'(j)) == 0);
            if (j < 8) br(8'h80 | 8'(j), (f[2:0] & 3'(j)) != 0);
        end
        ex(CARC_OP_JUMP, 8'h12, 8'h34);
        rd(CARC_OFF_IP, 32'h1234);
        ex(CARC_OP_CALL, 8'hab, 8'hcd);
        rd(CARC_OFF_RET, 32'h1237);
        ex(CARC_OP_RETURN);
        rd(CARC_OFF_IP, 32'h1237);
        apb(1, CARC_OFF_DP, 32'h40);
        ex(CARC_OP_LOADM);
        rd(CARC_OFF_ACC, 8'hc3);
        ex(CARC_OP_STOREM);
        rd(CARC_OFF_DP, 32'h42);
        apb(1, CARC_OFF_DP, 32'h41);
        ex(CARC_OP_LOADM);
        rd(CARC_OFF_ACC, 8'hc3);
        ex(CARC_OP_DPIMM, 8'h20, 8'h10);
        ex(CARC_OP_LI, 8'hfe);
        ex(CARC_OP_ADDDP);
        rd(CARC_OFF_DP, 32'h200e);
        ex(CARC_OP_Q_DP);
        ex(CARC_OP_JMPQ);
        rd(CARC_OFF_IP, 32'h200e);
        ex(CARC_OP_XDP);
        rd(CARC_OFF_DP2, 32'h200e);
        ex(CARC_OP_J_W);
        apb(1, CARC_OFF_SIDX, 9);
        rd(CARC_OFF_SDATA, f);
        ex(CARC_OP_K_RET);
        ex(CARC_OP_A_KU);
        rd(CARC_OFF_ACC, 8'h12);
        ex(CARC_OP_A_KL);
        rd(CARC_OFF_ACC, 8'h37);
        ex(CARC_OP_LI, 8'h5c);
        ex(CARC_OP_KU_A);
        ex(CARC_OP_RET_K);
        rd(CARC_OFF_RET, 32'h5c37);
        apb(1, CARC_OFF_IP, 32'h0300);
        ex(CARC_OP_CALLK);
        rd(CARC_OFF_IP, 32'h5c37);
        rd(CARC_OFF_RET, 32'h0301);
        ex(CARC_OP_LI, 8'h4a);
        ex(CARC_OP_QU_A);
        ex(CARC_OP_LI, 8'h71);
        ex(CARC_OP_QL_A);
        ex(CARC_OP_A_QU);
        rd(CARC_OFF_ACC, 8'h4a);
        ex(CARC_OP_DP_Q);
        rd(CARC_OFF_DP, 32'h4a71);
        ex(CARC_OP_H_DP);
        ex({CARC_OG_SP_LOAD, 4'hb});
        rd(CARC_OFF_ACC, 8'h71);
        apb(1, CARC_OFF_DP, 0);
        ex(CARC_OP_DP_H);
        rd(CARC_OFF_DP, 32'h4a71);
        // scratch index still selects the flag save slot
        apb(1, CARC_OFF_SDATA, f ^ 4'hf);
        ex(CARC_OP_W_J);
        rd(CARC_OFF_FLAGS, f ^ 4'hf);
        psel <= 0;
        @(posedge pclk);
        close_out();
    end
endmodule
